// file: mcs_pkg.sv
// Behaviour
// - laser regulation three seconds, symbol flashing
// - measuring time clamped to 30..300 seconds
// - measuring time defaults to sixty seconds
// - pause 1..86400 s, default ten, alternating
// - timed mode counts remaining time down
// - shortened pause shows dashes until expiry
// - external mode measures while input high
// - input/button modes count up, hold last
// - button or serial command starts/stops measurement
// - auto ends at target and 45s, or past 300s
// - particle target defaults 200, serial command only
// - auto mode restarts at once, no pause
// - exactly four operating modes
// - any alarm drives lamp, symbol, switch, code
// - zero result skips all but temperature alarm
// - select advances digit, arrows change, commit last
// - both arrows go back, discard edit
// - ISO classes one..six shown as six-or-less
// - NAS or GOST shows one ordinal
package mcs_pkg;
    // ****************************************
    // constants
    // ****************************************
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned TICK_CYCLES = CLK_HZ;
    localparam logic [31:0] TICK_LAST = 32'h0773593f;
    localparam logic [1:0] LASER_S = 2'h3;
    localparam logic [8:0] MEAS_MIN_S = 9'h01e;
    localparam logic [8:0] MEAS_MAX_S = 9'h12c;
    localparam logic [8:0] MEAS_DEF_S = 9'h03c;
    localparam logic [16:0] PAUSE_MIN_S = 17'h00001;
    localparam logic [16:0] PAUSE_MAX_S = 17'h15180;
    localparam logic [16:0] PAUSE_DEF_S = 17'h0000a;
    localparam logic [8:0] AUTO_MIN_S = 9'h02d;
    localparam logic [8:0] AUTO_MAX_S = 9'h12c;
    localparam logic [15:0] TARGET_DEF = 16'h00c8;
    localparam logic [4:0] ISO_LE6_MAX = 5'h06;
    localparam logic [4:0] ISO_LE6_MIN = 5'h01;
    localparam logic [2:0] EDIT_DIGITS = 3'h5;
    localparam logic [7:0] FAULT_ALARM_BITS = 8'h07;
    typedef enum logic [1:0] {
        MCS_TIMED, MCS_EXTIN, MCS_BUTTON, MCS_AUTO
    } mcs_mode_type;
    typedef enum logic [1:0] {
        MCS_ST_PAUSE, MCS_ST_LASER, MCS_ST_MEAS
    } mcs_phase_type;
    typedef enum logic [1:0] {
        MCS_STD_ISO, MCS_STD_SAE, MCS_STD_NAS, MCS_STD_GOST
    } mcs_std_type;
    localparam logic [31:0] R_MODE = 32'h00000000;
    localparam logic [31:0] R_MEAS = 32'h00000004;
    localparam logic [31:0] R_PAUSE = 32'h00000008;
    localparam logic [31:0] R_TARGET = 32'h0000000c;
    localparam logic [31:0] R_STATUS = 32'h00000010;
    localparam logic [31:0] R_TIME = 32'h00000014;
    localparam logic [31:0] R_EDIT = 32'h00000018;
    localparam logic [31:0] R_ORD = 32'h0000001c;
endpackage : mcs_pkg

// file: mcs_sequencer.sv
`timescale 1ns/1ps
module mcs_sequencer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic start_stop_in,
    input wire logic btn_select,
    input wire logic btn_up,
    input wire logic btn_down,
    input wire logic cmd_start,
    input wire logic cmd_stop,
    input wire logic auto_particle_target_command,
    input wire logic [15:0] cmd_target_value,
    input wire logic particle_pulse,
    input wire logic [4:0] result_ord,
    input wire logic result_valid,
    input wire logic alarm_std,
    input wire logic alarm_filter,
    input wire logic alarm_temp,
    output logic meas_done,
    output logic run_symbol,
    output logic pause_symbol,
    output logic dash_display,
    output logic [16:0] time_display,
    output logic alarm_lamp,
    output logic warn_symbol,
    output logic switch_out,
    output logic [7:0] fault_code_word,
    output logic [4:0] shown_ord,
    output logic shown_le6
);
    import mcs_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [31:0] div;
        logic tick;
        logic blink;
        mcs_mode_type mode;
        mcs_std_type std;
        mcs_phase_type phase;
        logic [8:0] meas_set;
        logic [16:0] pause_set;
        logic [15:0] target;
        logic [16:0] elapsed;
        logic [16:0] remain;
        logic [8:0] last_len;
        logic [15:0] count;
        logic [1:0] laser;
        logic dash;
        logic sel_prev;
        logic both_prev;
        logic editing;
        logic [2:0] digit;
        logic [3:0] edit_val;
        logic [3:0] edit_commit;
        logic aph;
        logic apw;
        logic [31:0] aaddr;
        logic [31:0] rdata;
        logic done;
        logic [16:0] tdisp;
        logic lamp;
        logic warn;
        logic sw;
        logic [7:0] fcw;
        logic [4:0] ord;
        logic le6;
        logic zero;
        logic run_sym;
        logic pause_sym;
    } mcs_state_type;

    mcs_state_type s_q, s_d;

    function automatic logic [8:0] clamp_meas(input logic [31:0] v);
        if (v < {23'h000000, MEAS_MIN_S}) clamp_meas = MEAS_MIN_S;
        else if (v > {23'h000000, MEAS_MAX_S}) clamp_meas = MEAS_MAX_S;
        else clamp_meas = v[8:0];
    endfunction

    function automatic logic [16:0] clamp_pause(input logic [31:0] v);
        if (v < {15'h0000, PAUSE_MIN_S}) clamp_pause = PAUSE_MIN_S;
        else if (v > {15'h0000, PAUSE_MAX_S}) clamp_pause = PAUSE_MAX_S;
        else clamp_pause = v[16:0];
    endfunction

    logic start_req, stop_req, run_in, sel_edge, both, both_edge;
    logic meas_end, alarm_any, zero_res;

    always_comb begin
        s_d = s_q;
        start_req = 1'b0;
        stop_req = 1'b0;
        meas_end = 1'b0;
        both = btn_up & btn_down;
        both_edge = both & ~s_q.both_prev;
        sel_edge = btn_select & ~s_q.sel_prev;
        run_in = start_stop_in;
        s_d.sel_prev = btn_select;
        s_d.both_prev = both;
        s_d.done = 1'b0;
        s_d.tick = 1'b0;
        if (s_q.div == TICK_LAST) begin
            s_d.div = 32'h00000000;
            s_d.tick = 1'b1;
            s_d.blink = ~s_q.blink;
        end else begin
            s_d.div = s_q.div + 32'h00000001;
        end

        // ****************************************
        // menu editing
        // ****************************************
        // both arrows back, discard
        if (both_edge) begin
            s_d.editing = 1'b0;
            s_d.digit = 3'h0;
            s_d.edit_val = s_q.edit_commit;
        end else if (s_q.editing) begin
            if (sel_edge) begin
                if (s_q.digit == EDIT_DIGITS - 3'h1) begin
                    s_d.edit_commit = s_q.edit_val;
                    s_d.editing = 1'b0;
                    s_d.digit = 3'h0;
                end else begin
                    s_d.digit = s_q.digit + 3'h1;
                end
            end else if (btn_up & ~btn_down) begin
                s_d.edit_val = s_q.edit_val + 4'h1;
            end else if (btn_down & ~btn_up) begin
                s_d.edit_val = s_q.edit_val - 4'h1;
            end
        end else if (sel_edge && s_q.mode != MCS_BUTTON) begin
            // select opens an edit outside button mode
            s_d.editing = 1'b1;
            s_d.digit = 3'h0;
            s_d.edit_val = s_q.edit_commit;
        end

        // ****************************************
        // run requests per mode
        // ****************************************
        case (s_q.mode)
            MCS_EXTIN: begin
                start_req = run_in;
                stop_req = ~run_in;
            end
            MCS_BUTTON: begin
                start_req = cmd_start | (sel_edge & ~s_q.editing);
                stop_req = cmd_stop | (sel_edge & ~s_q.editing);
            end
            default: begin
            end
        endcase

        // ****************************************
        // phase sequencing
        // ****************************************
        if (s_q.tick && s_q.phase == MCS_ST_MEAS && particle_pulse) begin
            s_d.count = s_q.count;
        end
        if (particle_pulse && s_q.phase == MCS_ST_MEAS &&
            s_q.count != 16'hffff) begin
            s_d.count = s_q.count + 16'h0001;
        end
        case (s_q.phase)
            MCS_ST_PAUSE: begin
                if (s_q.mode == MCS_TIMED) begin
                    if (s_q.tick) begin
                        if (s_q.remain <= 17'h00001) begin
                            s_d.phase = MCS_ST_LASER;
                            s_d.dash = 1'b0;
                        end else begin
                            s_d.remain = s_q.remain - 17'h00001;
                            s_d.elapsed = s_q.elapsed + 17'h00001;
                        end
                    end
                end else if (s_q.mode == MCS_AUTO || start_req) begin
                    s_d.phase = MCS_ST_LASER;
                end
                if (s_d.phase == MCS_ST_LASER) begin
                    s_d.laser = 2'h0;
                    s_d.elapsed = 17'h00000;
                    s_d.count = 16'h0000;
                    s_d.remain = {8'h00, s_q.meas_set};
                    s_d.dash = 1'b0;
                end
            end
            MCS_ST_LASER: begin
                if (s_q.tick) begin
                    if (s_q.laser == LASER_S - 2'h1) begin
                        s_d.phase = MCS_ST_MEAS;
                    end else begin
                        s_d.laser = s_q.laser + 2'h1;
                    end
                end
                if (s_q.mode != MCS_TIMED && s_q.mode != MCS_AUTO &&
                    stop_req && !start_req) begin
                    s_d.phase = MCS_ST_PAUSE;
                end
            end
            MCS_ST_MEAS: begin
                if (s_q.tick) begin
                    s_d.elapsed = s_q.elapsed + 17'h00001;
                    if (s_q.remain != 17'h00000) begin
                        s_d.remain = s_q.remain - 17'h00001;
                    end
                end
                case (s_q.mode)
                    MCS_TIMED: meas_end = s_q.tick &&
                        s_q.remain <= 17'h00001;
                    MCS_AUTO: meas_end =
                        (s_q.count >= s_q.target &&
                         s_q.elapsed >= {8'h00, AUTO_MIN_S}) ||
                        s_q.elapsed > {8'h00, AUTO_MAX_S};
                    default: meas_end = stop_req;
                endcase
                if (meas_end) begin
                    s_d.done = 1'b1;
                    s_d.last_len = s_q.elapsed[8:0];
                    if (s_q.mode == MCS_AUTO) begin
                        s_d.phase = MCS_ST_LASER;
                        s_d.laser = 2'h0;
                        s_d.elapsed = 17'h00000;
                        s_d.count = 16'h0000;
                    end else begin
                        s_d.phase = MCS_ST_PAUSE;
                        s_d.remain = s_q.pause_set;
                        s_d.dash = 1'b0;
                        s_d.elapsed = 17'h00000;
                    end
                end
            end
            default: s_d.phase = MCS_ST_PAUSE;
        endcase

        // ****************************************
        // register bus
        // ****************************************
        if (s_q.aph && s_q.apw) begin
            case (s_q.aaddr)
                R_MODE: begin
                    s_d.mode = mcs_mode_type'(hwdata[1:0]);
                    s_d.std = mcs_std_type'(hwdata[5:4]);
                end
                R_MEAS: s_d.meas_set = clamp_meas(hwdata);
                R_PAUSE: begin
                    s_d.pause_set = clamp_pause(hwdata);
                    if (s_d.phase == MCS_ST_PAUSE &&
                        s_q.mode == MCS_TIMED &&
                        clamp_pause(hwdata) < s_q.elapsed) begin
                        s_d.dash = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        if (auto_particle_target_command) begin
            s_d.target = cmd_target_value;
        end
        s_d.aph = hsel & htrans[1] & hready;
        s_d.apw = hwrite;
        s_d.aaddr = haddr;
        s_d.rdata = 32'h00000000;
        if (hsel & htrans[1] & hready & ~hwrite) begin
            case (haddr)
                R_MODE: s_d.rdata = {26'h0000000, s_q.std, 2'h0, s_q.mode};
                R_MEAS: s_d.rdata = {23'h000000, s_q.meas_set};
                R_PAUSE: s_d.rdata = {15'h0000, s_q.pause_set};
                R_TARGET: s_d.rdata = {16'h0000, s_q.target};
                R_STATUS: s_d.rdata = {s_q.count, 7'h00, s_q.dash,
                    s_q.lamp, 3'h0, s_q.phase, 2'h0};
                R_TIME: s_d.rdata = {15'h0000, s_q.tdisp};
                R_EDIT: s_d.rdata = {23'h000000, s_q.editing, s_q.digit,
                    1'b0, s_q.edit_commit};
                R_ORD: s_d.rdata = {26'h0000000, s_q.le6, s_q.ord};
                default: s_d.rdata = 32'h00000000;
            endcase
        end

        // ****************************************
        // display and alarms
        // ****************************************
        // timed counts down, others count up, hold last length
        if (s_q.mode == MCS_TIMED) begin
            s_d.tdisp = s_q.remain;
        end else if (s_q.phase == MCS_ST_PAUSE) begin
            s_d.tdisp = {8'h00, s_q.last_len};
        end else begin
            s_d.tdisp = s_q.elapsed;
        end
        zero_res = result_valid ? result_ord == 5'h00 : s_q.zero;
        // zero result held until the next one
        s_d.zero = zero_res;
        alarm_any = alarm_temp | (~zero_res & (alarm_std | alarm_filter));
        s_d.lamp = alarm_any;
        s_d.warn = alarm_any & s_q.blink;
        s_d.sw = alarm_any;
        s_d.fcw = alarm_any ? FAULT_ALARM_BITS : 8'h00;
        if (result_valid) begin
            s_d.ord = result_ord;
            s_d.le6 = s_q.std == MCS_STD_ISO &&
                result_ord >= ISO_LE6_MIN && result_ord <= ISO_LE6_MAX;
        end

        // ****************************************
        // symbol outputs
        // ****************************************
        // run symbol flashes during laser phase
        s_d.run_sym = s_d.phase == MCS_ST_MEAS ||
            (s_d.phase == MCS_ST_LASER && s_d.blink);
        s_d.pause_sym = s_d.phase == MCS_ST_PAUSE;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.meas_set <= MEAS_DEF_S;
            s_q.pause_set <= PAUSE_DEF_S;
            s_q.target <= TARGET_DEF;
            s_q.phase <= MCS_ST_PAUSE;
            s_q.remain <= PAUSE_DEF_S;
            s_q.pause_sym <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata = s_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign meas_done = s_q.done;
    assign run_symbol = s_q.run_sym;
    assign pause_symbol = s_q.pause_sym;
    assign dash_display = s_q.dash;
    assign time_display = s_q.tdisp;
    assign alarm_lamp = s_q.lamp;
    assign warn_symbol = s_q.warn;
    assign switch_out = s_q.sw;
    assign fault_code_word = s_q.fcw;
    // one ordinal for NAS or GOST
    assign shown_ord = s_q.ord;
    assign shown_le6 = s_q.le6;
endmodule // mcs_sequencer

// file: mcs_seq_asserts.sv
`timescale 1ns/1ps
module mcs_seq_asserts
    import mcs_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic result_valid,
    input wire logic [4:0] result_ord,
    input wire logic alarm_std,
    input wire logic alarm_filter,
    input wire logic alarm_temp,
    input wire logic meas_done,
    input wire logic run_symbol,
    input wire logic pause_symbol,
    input wire logic dash_display,
    input wire logic alarm_lamp,
    input wire logic switch_out,
    input wire logic [7:0] fault_code_word,
    input wire logic [4:0] shown_ord,
    input wire logic shown_le6
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ****
    // alarm sequences
    // ****
    sequence temp_held;
        alarm_temp [*3];
    endsequence
    sequence all_quiet;
        (!alarm_std && !alarm_filter && !alarm_temp) [*3];
    endsequence
    AST_ALARM_ON: assert property (temp_held |->
        alarm_lamp && switch_out)
        else $error("alarm outputs off while temperature alarm held");
    AST_ALARM_OFF: assert property (all_quiet |->
        !alarm_lamp && !switch_out)
        else $error("alarm outputs on with no alarm source");
    AST_FAULT_BITS: assert property (alarm_lamp |->
        (fault_code_word & FAULT_ALARM_BITS) == FAULT_ALARM_BITS)
        else $error("fault code bits missing during alarm");
    AST_LE6_OUT: assert property (result_valid &&
        (result_ord > ISO_LE6_MAX || result_ord < ISO_LE6_MIN) |=> !shown_le6)
        else $error("six-or-less shown for ordinal outside range");
    AST_ORD_SHOWN: assert property (result_valid |=>
        shown_ord == $past(result_ord))
        else $error("shown ordinal differs from result");
    AST_SYMBOLS: assert property (!(run_symbol && pause_symbol))
        else $error("run and pause symbols lit together");
    AST_DASH_PAUSE: assert property (dash_display |-> pause_symbol)
        else $error("dashes shown outside pause");
    AST_DONE_PULSE: assert property (meas_done |=> !meas_done)
        else $error("measurement done longer than one cycle");
    cover property (meas_done);
endmodule // mcs_seq_asserts

bind mcs_sequencer mcs_seq_asserts chk_u (.hclk, .hresetn, .result_valid,
    .result_ord, .alarm_std, .alarm_filter, .alarm_temp, .meas_done,
    .run_symbol, .pause_symbol, .dash_display, .alarm_lamp, .switch_out,
    .fault_code_word, .shown_ord, .shown_le6);

// file: mcs_ext_ctrl.sv
`timescale 1ns/1ps
module mcs_ext_ctrl (
    input wire logic hclk,
    output logic start_stop_in,
    output logic cmd_start,
    output logic cmd_stop,
    output logic auto_particle_target_command,
    output logic [15:0] cmd_target_value
);
    initial begin
        start_stop_in = 1'b1;
        cmd_start = 1'b0;
        cmd_stop = 1'b0;
        auto_particle_target_command = 1'b0;
        cmd_target_value = 16'h5a5a;
    end
    task automatic set_level(input logic lvl);
        @(posedge hclk);
        start_stop_in <= lvl;
    endtask
    task automatic send(input logic stop);
        @(posedge hclk);
        cmd_start <= !stop;
        cmd_stop <= stop;
        @(posedge hclk);
        cmd_start <= 1'b0;
        cmd_stop <= 1'b0;
    endtask
    task automatic load_target(input logic [15:0] v);
        @(posedge hclk);
        auto_particle_target_command <= 1'b1;
        cmd_target_value <= v;
        @(posedge hclk);
        auto_particle_target_command <= 1'b0;
        cmd_target_value <= ~v;
    endtask
endmodule // mcs_ext_ctrl

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import mcs_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic btn_select = 1'b0, result_valid = 1'b0, alarm_std = 1'b0;
    logic alarm_filter = 1'b0, alarm_temp = 1'b0;
    logic btn_up = 1'b0, btn_down = 1'b0, particle_pulse = 1'b0;
    logic [4:0] result_ord = 5'h00, shown_ord;
    logic hready, hreadyout, hresp, start_stop_in, cmd_start, cmd_stop;
    logic tgt_cmd, meas_done, run_symbol, pause_symbol, dash_display;
    logic alarm_lamp, warn_symbol, switch_out, shown_le6;
    logic [15:0] tgt_val;
    logic [16:0] time_display;
    logic [7:0] fault_code_word;
    logic [31:0] lim[8][3] = '{'{R_MEAS, 32'h1d, 32'h1e},
        '{R_MEAS, 32'h12d, 32'h12c}, '{R_MEAS, 32'h1e, 32'h1e},
        '{R_MEAS, 32'h12c, 32'h12c}, '{R_PAUSE, 32'h0, 32'h1},
        '{R_PAUSE, 32'h15181, 32'h15180}, '{R_PAUSE, 32'h1, 32'h1},
        '{R_PAUSE, 32'h15180, 32'h15180}};
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    int dones = 0;
    assign hready = hreadyout;
    always #4 hclk = ~hclk;
    mcs_sequencer dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
        .start_stop_in, .btn_select, .btn_up, .btn_down,
        .cmd_start, .cmd_stop, .auto_particle_target_command(tgt_cmd),
        .cmd_target_value(tgt_val), .particle_pulse, .result_ord,
        .result_valid, .alarm_std, .alarm_filter, .alarm_temp, .meas_done,
        .run_symbol, .pause_symbol, .dash_display, .time_display,
        .alarm_lamp, .warn_symbol, .switch_out, .fault_code_word,
        .shown_ord, .shown_le6);
    mcs_ext_ctrl ctl_u (.hclk, .start_stop_in, .cmd_start, .cmd_stop,
        .auto_particle_target_command(tgt_cmd), .cmd_target_value(tgt_val));
    // ****
    // run control
    // ****
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge hclk) begin
        cycles++;
        if (meas_done === 1'b1) dones++;
        if (cycles == 20000) begin
            num_errors++;
            $display("unexpected at %0t: run too long", $time);
            give_verdict();
        end
    end
    // ****
    // bus and compare tasks
    // ****
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        if (wr) hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic chk_pin(input logic [31:0] got, exp, input string what);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [31:0] a, exp);
        bus(1'b0, a, 32'h0);
        chk_pin(rd, exp, "register");
    endtask
    task automatic chk_phase(input logic [1:0] ph);
        int n;
        n = 0;
        do begin
            bus(1'b0, R_STATUS, 32'h0);
            n++;
        end while (rd[3:2] !== ph && n < 40);
        chk_pin({30'h0, rd[3:2]}, {30'h0, ph}, "phase");
    endtask
    task automatic result(input logic [4:0] v);
        result_ord <= v;
        result_valid <= 1'b1;
        @(posedge hclk);
        result_valid <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask
    task automatic press(input logic [2:0] b);
        {btn_select, btn_up, btn_down} <= b;
        @(posedge hclk);
        {btn_select, btn_up, btn_down} <= 3'h0;
        @(posedge hclk);
    endtask
    // ****
    // tests
    // ****
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk_pin(pause_symbol, 1'b1, "pause symbol");
        chk_reg(R_MEAS, 32'h3c);
        chk_reg(R_PAUSE, 32'ha);
        chk_reg(R_TARGET, 32'hc8);
        chk_pin(time_display, 32'ha, "pause countdown");
        chk_reg(32'h40, 32'h0);
        $display("test defaults done");
        foreach (lim[i]) begin
            bus(1'b1, lim[i][0], lim[i][1]);
            chk_reg(lim[i][0], lim[i][2]);
        end
        bus(1'b1, R_MEAS, 32'h78);
        chk_reg(R_MEAS, 32'h78);
        chk_pin(dash_display, 1'b0, "dash");
        bus(1'b1, R_TARGET, 32'h5);
        chk_reg(R_TARGET, 32'hc8);
        ctl_u.load_target(16'h01f4);
        chk_reg(R_TARGET, 32'h1f4);
        $display("test limits done");
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, R_MODE, m);
            chk_reg(R_MODE, m);
        end
        chk_phase(2'h1);
        bus(1'b1, R_MODE, 32'h1);
        ctl_u.set_level(1'b0);
        chk_phase(2'h0);
        ctl_u.set_level(1'b1);
        chk_phase(2'h1);
        ctl_u.set_level(1'b0);
        chk_phase(2'h0);
        $display("test modes done");
        bus(1'b1, R_MODE, 32'h2);
        btn_select <= 1'b1;
        repeat (3) @(posedge hclk);
        btn_select <= 1'b0;
        chk_phase(2'h1);
        ctl_u.send(1'b1);
        chk_phase(2'h0);
        ctl_u.send(1'b0);
        chk_phase(2'h1);
        ctl_u.send(1'b1);
        chk_phase(2'h0);
        // stopped while still in laser phase, nothing completes
        chk_pin(dones, 0, "done count");
        $display("test button done");
        alarm_temp <= 1'b1;
        repeat (4) @(posedge hclk);
        chk_pin(alarm_lamp, 1'b1, "lamp");
        chk_pin(switch_out, 1'b1, "switch");
        chk_pin(fault_code_word & 8'h07, 8'h07, "fault code");
        alarm_temp <= 1'b0;
        result(5'h00);
        alarm_std <= 1'b1;
        repeat (4) @(posedge hclk);
        chk_pin(alarm_lamp, 1'b0, "lamp zero result");
        result(5'h05);
        chk_pin(alarm_lamp, 1'b1, "lamp standard");
        alarm_std <= 1'b0;
        alarm_filter <= 1'b1;
        repeat (4) @(posedge hclk);
        chk_pin(switch_out, 1'b1, "switch filter");
        alarm_filter <= 1'b0;
        repeat (4) @(posedge hclk);
        chk_pin(alarm_lamp, 1'b0, "lamp cleared");
        $display("test alarms done");
        bus(1'b1, R_MODE, 32'h0);
        result(5'h03);
        chk_pin(shown_le6, 1'b1, "six or less");
        result(5'h07);
        chk_pin({shown_le6, shown_ord}, 6'h07, "iso seven");
        bus(1'b1, R_MODE, 32'h20);
        result(5'h03);
        chk_pin({shown_le6, shown_ord}, 6'h03, "single ordinal");
        $display("test ordinals done");
        press(3'h4);
        press(3'h2);
        press(3'h4);
        chk_reg(R_EDIT, 32'h120);
        repeat (4) press(3'h4);
        chk_reg(R_EDIT, 32'h1);
        press(3'h4);
        press(3'h2);
        press(3'h3);
        chk_reg(R_EDIT, 32'h1);
        particle_pulse <= 1'b1;
        @(posedge hclk);
        particle_pulse <= 1'b0;
        bus(1'b0, R_STATUS, 32'h0);
        chk_pin({16'h0, rd[31:16]}, 32'h0, "count in pause");
        $display("test edit done");
        give_verdict();
    end
endmodule // tb_top
